/* adcs_top.sv */
// Function
// RULE_01: Reference code 00 picks external pin, 01/11 supply, 10 sensor reference.
// RULE_02: Source 000/101/110 external, 001 bandgap, 010 sensor output, 011/100 ground.
// RULE_03: Writes of source code 111 are rejected; field keeps its old value.
// RULE_04: Channel codes 0-7 connect one pin; codes 8-15 connect none.
// RULE_05: Software parks channel at 8-15 before picking an internal source.
// RULE_06: Analog pins drop other functions, pull-up and direction control.
// RULE_07: 12-bit, normal input: 4 sample plus 12 convert clocks.
// RULE_08: 12-bit, sensor input: 46 sample plus 12 convert clocks.
// RULE_09: 10-bit, low current: 2 sample plus 10 convert clocks.
// RULE_10: 10-bit, other rates: 3 sample plus 10 convert clocks.
// RULE_11: Software uses the sensor only at 12-bit and fastest rate.
// RULE_12: Software starts a conversion by pulsing start high then low.
// RULE_13: Busy is high during conversion; result then sits in result registers.
// RULE_14: Conversion runs on its own without stalling the processor.
// RULE_15: Power enable low shuts the converter core down completely.
// RULE_16: Full scale is 3FF at 10-bit and FFF at 12-bit.
// RULE_17: Format bit chooses result alignment across high and low bytes.
// RULE_18: Software sets both interrupt enables when using interrupts.
// RULE_19: Software enables the sensor before picking its reference.
// RULE_20: Each completion sets the flag; request only when both enables set.
// RULE_21: Rate field chooses 2MHz, 1MHz, 500kHz or low current mode.
// RULE_22: Converter clock is system clock divided by 1 to 128.
// RULE_23: Busy and sampling begin the cycle after start returns low.
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module adcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog core
  output adcs_pkg::adcs_ana_t ana,
  input wire logic [11:0] core_data,
  // Pin multiplexer
  output adcs_pkg::adcs_pin_t pin,
  // Events
  output logic irq,
  output logic eoc
);
  import adcs_pkg::*;

  adcs_ctrl0_t ctrl0;
  adcs_ctrl1_t ctrl1;
  adcs_ctrl2_t ctrl2;
  adcs_intc_t intc;
  adcs_state_t state;
  logic [7:0] pin_sel;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic busy;
  logic start_d;
  logic start_fall;
  logic tick;
  logic [5:0] cnt;
  logic [5:0] samp_need;
  logic [5:0] conv_need;
  logic res10_q;
  logic done;
  logic [15:0] aligned;
  logic addr_ok;
  logic wr_pend;
  logic rd_wait;
  logic [7:0] d_addr;
  logic [31:0] rd_val;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_intc;

  // Bus address phase capture
  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = !rd_wait; // RULE_14
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      d_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite && (hsize == SIZE_WORD);
      rd_wait <= addr_ok && !hwrite;
      if (addr_ok) begin
        d_addr <= haddr[7:0];
      end
    end
  end

  // Write strobes in the data phase
  assign wr_ctrl0 = wr_pend && (d_addr == ADDR_CTRL0);
  assign wr_ctrl1 = wr_pend && (d_addr == ADDR_CTRL1);
  assign wr_ctrl2 = wr_pend && (d_addr == ADDR_CTRL2);
  assign wr_intc = wr_pend && (d_addr == ADDR_INTC);

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (d_addr)
      ADDR_CTRL0: rd_val[7:0] = {ctrl0.start, busy, ctrl0.power_en, ctrl0.fmt, ctrl0.channel};
      ADDR_CTRL1: rd_val[7:0] = ctrl1;
      ADDR_CTRL2: rd_val[7:0] = ctrl2;
      ADDR_RES_HI: rd_val[7:0] = res_hi;
      ADDR_RES_LO: rd_val[7:0] = res_lo;
      ADDR_INTC: rd_val[7:0] = intc;
      ADDR_PINSEL: rd_val[7:0] = pin_sel;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data registered during the single wait state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
      hrdata <= rd_val;
    end
  end

  // Control register 0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0 <= CTRL0_RST;
    end else if (wr_ctrl0) begin
      ctrl0 <= {hwdata[7], 1'b0, hwdata[5:0]};
    end
  end

  // Control register 1; forbidden source code leaves the field alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1 <= CTRL1_RST;
    end else if (wr_ctrl1) begin
      ctrl1.ref_src <= hwdata[4:3];
      ctrl1.div <= hwdata[2:0];
      if (hwdata[7:5] != SRC_BAD) begin // RULE_03
        ctrl1.src <= hwdata[7:5];
      end
    end
  end

  // Control register 2 and pin function select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl2 <= CTRL2_RST;
      pin_sel <= PINSEL_RST;
    end else begin
      if (wr_ctrl2) begin
        ctrl2 <= {hwdata[7:5], 4'h0, hwdata[0]};
      end
      if (wr_pend && (d_addr == ADDR_PINSEL)) begin
        pin_sel <= hwdata[7:0];
      end
    end
  end

  // Interrupt flag and enables; completion wins over a software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intc <= 8'h00;
    end else begin
      if (wr_intc) begin
        intc.gie <= hwdata[2];
        intc.cie <= hwdata[1];
      end
      if (done) begin
        intc.flag <= 1'b1; // RULE_20
      end else if (wr_intc && !hwdata[0]) begin
        intc.flag <= 1'b0;
      end
    end
  end

  assign irq = intc.flag && intc.cie && intc.gie; // RULE_20

  // Start falls low: begin a conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_d <= 1'b0;
    end else begin
      start_d <= ctrl0.start;
    end
  end

  assign start_fall = start_d && !ctrl0.start; // RULE_12

  adcs_clkdiv u_div (
    .clk(clk),
    .rstn(rstn),
    .div_sel(ctrl1.div),
    .restart(start_fall),
    .tick(tick)
  );

  // Sampling and conversion sequencer, never holds off the bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      cnt <= 6'h00;
      samp_need <= SAMP_12;
      conv_need <= CONV_12;
      res10_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!ctrl0.power_en || ctrl0.start) begin // RULE_15
        state <= ST_IDLE;
        busy <= 1'b0;
        cnt <= 6'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_fall) begin // RULE_23
              state <= ST_SAMPLE;
              busy <= 1'b1; // RULE_13
              cnt <= 6'h00;
              samp_need <= adcs_samp_clocks(ctrl2.res10, ctrl2.rate,
                                            ctrl1.src == SRC_TSO); // RULE_07 RULE_08 RULE_09 RULE_10
              conv_need <= adcs_conv_clocks(ctrl2.res10);
              res10_q <= ctrl2.res10;
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (cnt == 6'(samp_need - 6'h01)) begin
                state <= ST_CONVERT;
                cnt <= 6'h00;
              end else begin
                cnt <= 6'(cnt + 6'h01);
              end
            end
          end
          ST_CONVERT: begin
            if (tick) begin
              if (cnt == 6'(conv_need - 6'h01)) begin
                state <= ST_IDLE;
                busy <= 1'b0; // RULE_13
                cnt <= 6'h00;
                done <= 1'b1;
              end else begin
                cnt <= 6'(cnt + 6'h01);
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // Result capture in the chosen alignment
  assign aligned = adcs_align(core_data, res10_q, ctrl0.fmt); // RULE_16 RULE_17

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_hi <= 8'h00;
      res_lo <= 8'h00;
      eoc <= 1'b0;
    end else begin
      eoc <= 1'b0;
      if (!ctrl0.start && ctrl0.power_en && state == ST_CONVERT && tick &&
          cnt == 6'(conv_need - 6'h01)) begin
        res_hi <= aligned[15:8]; // RULE_13
        res_lo <= aligned[7:0];
        eoc <= 1'b1;
      end
    end
  end

  // Analog core controls, all gated by power enable
  always_comb begin
    ana = '0;
    ana.power_en = ctrl0.power_en; // RULE_15
    if (ctrl0.power_en) begin
      ana.ref_ext = (ctrl1.ref_src == REF_EXT); // RULE_01
      ana.ref_tsvref = (ctrl1.ref_src == REF_TS);
      ana.ref_vdd = ctrl1.ref_src[0];
      ana.in_ext = (ctrl1.src == SRC_EXT0) || (ctrl1.src == SRC_EXT1) ||
                   (ctrl1.src == SRC_EXT2); // RULE_02
      ana.in_bandgap = (ctrl1.src == SRC_BG);
      ana.in_tso = (ctrl1.src == SRC_TSO);
      ana.in_gnd = (ctrl1.src == SRC_GND0) || (ctrl1.src == SRC_GND1);
      ana.chan = ctrl0.channel[3] ? 8'h00 : 8'(8'h01 << ctrl0.channel[2:0]); // RULE_04
      ana.ts_en = ctrl2.ts_en;
      ana.res10 = ctrl2.res10;
      ana.rate = ctrl2.rate; // RULE_21
      ana.sample = (state == ST_SAMPLE);
      ana.convert = (state == ST_CONVERT);
      ana.clk_tick = tick;
    end
  end

  // Analog pins lose digital function, pull-up and direction control
  assign pin.ana_sel = pin_sel; // RULE_06
  assign pin.digital_off = pin_sel;
  assign pin.pullup_off = pin_sel;
  assign pin.dir_override = pin_sel;

  // Helper: converter ticks seen since the start
  logic [6:0] tick_total;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_total <= 7'h00;
    end else if (start_fall) begin
      tick_total <= 7'h00;
    end else if (state != ST_IDLE && tick) begin
      tick_total <= 7'(tick_total + 7'h01);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_ref_decode: assert property (ana.power_en |-> (ana.ref_vdd == ctrl1.ref_src[0]) && // RULE_01
    (ana.ref_tsvref == (ctrl1.ref_src == 2'h2)) && (ana.ref_ext == (ctrl1.ref_src == 2'h0)))
    else $error("reference select decode wrong");
  chk_src_decode: assert property (ana.power_en |-> (ana.in_tso == (ctrl1.src == 3'h2)) && // RULE_02
    (ana.in_bandgap == (ctrl1.src == 3'h1)) && (ana.in_gnd == (ctrl1.src inside {3'h3, 3'h4})))
    else $error("input source decode wrong");
  chk_src_no_bad: assert property (wr_ctrl1 && hwdata[7:5] == 3'h7 |=> $stable(ctrl1.src) // RULE_03
    && ctrl1.src != 3'h7) else $error("forbidden source code stored");
  chk_chan_none: assert property (ctrl0.channel[3] || !ctrl0.power_en |-> ana.chan == 8'h00) // RULE_04
    else $error("pin connected for a non-existent channel");
  chk_pin_analog: assert property (wr_pend && d_addr == ADDR_PINSEL |=> // RULE_06
    pin.ana_sel == $past(hwdata[7:0]) && pin.digital_off == pin.ana_sel &&
    pin.pullup_off == pin.ana_sel && pin.dir_override == pin.ana_sel)
    else $error("analog pin keeps digital function");
  chk_busy_start: assert property (start_fall && ctrl0.power_en && state == ST_IDLE // RULE_23
    |=> busy && ana.sample) else $error("busy did not follow start");
  chk_seq_len: assert property (done |-> $past(tick_total) + 7'h01 == // RULE_07 RULE_08 RULE_09 RULE_10
    7'(samp_need + conv_need)) else $error("conversion length wrong");
  chk_busy_done: assert property (done |-> !busy ##1 intc.flag) // RULE_13 RULE_20
    else $error("completion did not clear busy or set flag");
  chk_full_scale: assert property (eoc && res10_q && ctrl0.fmt |-> res_hi[7:2] == 6'h00) // RULE_16
    else $error("10-bit result exceeds full scale");
  chk_power_off: assert property (!ctrl0.power_en |-> ana == '0 ##1 !busy) // RULE_15
    else $error("converter active while powered down");
  chk_bus_nostall: assert property (!hreadyout |=> hreadyout) // RULE_14
    else $error("bus held longer than one wait state");
  chk_irq_gate: assert property ($past(done) |-> irq == (intc.cie && intc.gie)) // RULE_20
    else $error("interrupt request not gated by enables");

  cov_conv_12: cover property (done && !res10_q);
  cov_conv_10: cover property (done && res10_q);
  cov_abort: cover property (busy && ctrl0.start);
  cov_bad_src: cover property (wr_ctrl1 && hwdata[7:5] == 3'h7);

endmodule : adcs_top
`default_nettype wire

/* adcs_pkg.sv */
package adcs_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_RES_HI = 8'h0C;
  localparam logic [7:0] ADDR_RES_LO = 8'h10;
  localparam logic [7:0] ADDR_INTC = 8'h14;
  localparam logic [7:0] ADDR_PINSEL = 8'h18;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // Register layouts
  typedef struct packed {
    logic start;
    logic busy;
    logic power_en;
    logic fmt;
    logic [3:0] channel;
  } adcs_ctrl0_t;

  typedef struct packed {
    logic [2:0] src;
    logic [1:0] ref_src;
    logic [2:0] div;
  } adcs_ctrl1_t;

  typedef struct packed {
    logic res10;
    logic [1:0] rate;
    logic [3:0] rsvd;
    logic ts_en;
  } adcs_ctrl2_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic gie;
    logic cie;
    logic flag;
  } adcs_intc_t;

  // Reset values
  localparam adcs_ctrl0_t CTRL0_RST = 8'h00;
  localparam adcs_ctrl1_t CTRL1_RST = 8'h00;
  localparam adcs_ctrl2_t CTRL2_RST = 8'h00;
  localparam logic [7:0] PINSEL_RST = 8'h00;

  // Source, reference and rate codes
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_TS = 2'h2;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_BG = 3'h1;
  localparam logic [2:0] SRC_TSO = 3'h2;
  localparam logic [2:0] SRC_GND0 = 3'h3;
  localparam logic [2:0] SRC_GND1 = 3'h4;
  localparam logic [2:0] SRC_EXT1 = 3'h5;
  localparam logic [2:0] SRC_EXT2 = 3'h6;
  localparam logic [2:0] SRC_BAD = 3'h7;
  localparam logic [1:0] RATE_LOW_CUR = 2'h3;

  // Phase lengths in converter clocks
  localparam logic [5:0] SAMP_12 = 6'h04;
  localparam logic [5:0] SAMP_12_TS = 6'h2E;
  localparam logic [5:0] SAMP_10_LC = 6'h02;
  localparam logic [5:0] SAMP_10 = 6'h03;
  localparam logic [5:0] CONV_12 = 6'h0C;
  localparam logic [5:0] CONV_10 = 6'h0A;
  localparam logic [11:0] FULL_10 = 12'h3FF;
  localparam logic [11:0] FULL_12 = 12'hFFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcs_state_t;

  // Controls towards the analog core
  typedef struct packed {
    logic power_en;
    logic ref_ext;
    logic ref_vdd;
    logic ref_tsvref;
    logic in_ext;
    logic in_bandgap;
    logic in_tso;
    logic in_gnd;
    logic [7:0] chan;
    logic ts_en;
    logic res10;
    logic [1:0] rate;
    logic sample;
    logic convert;
    logic clk_tick;
  } adcs_ana_t;

  // Controls towards the pin multiplexer
  typedef struct packed {
    logic [7:0] ana_sel;
    logic [7:0] digital_off;
    logic [7:0] pullup_off;
    logic [7:0] dir_override;
  } adcs_pin_t;

  // Sampling length for the selected mode
  function automatic logic [5:0] adcs_samp_clocks(input logic res10, input logic [1:0] rate,
                                                  input logic tso);
    if (!res10) begin
      return tso ? SAMP_12_TS : SAMP_12;
    end
    return (rate == RATE_LOW_CUR) ? SAMP_10_LC : SAMP_10;
  endfunction : adcs_samp_clocks

  // Conversion length for the selected resolution
  function automatic logic [5:0] adcs_conv_clocks(input logic res10);
    return res10 ? CONV_10 : CONV_12;
  endfunction : adcs_conv_clocks

  // Result split into high and low bytes
  function automatic logic [15:0] adcs_align(input logic [11:0] d, input logic res10,
                                             input logic fmt);
    logic [11:0] v;
    v = res10 ? (d & FULL_10) : (d & FULL_12);
    if (res10) begin
      return fmt ? {6'h00, v[9:0]} : {v[9:0], 6'h00};
    end
    return fmt ? {4'h0, v} : {v, 4'h0};
  endfunction : adcs_align

endpackage : adcs_pkg

/* adcs_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none

module adcs_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic [2:0] div_sel,
  input wire logic restart,
  // Converter clock tick
  output logic tick
);
  import adcs_pkg::*;

  logic [6:0] cnt;
  logic [6:0] mask;

  // All-ones mask of the selected power of two
  assign mask = 7'((8'h01 << div_sel) - 8'h01);

  // Free-running prescaler, realigned at each start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 7'h00;
    end else if (restart) begin
      cnt <= 7'h00;
    end else begin
      cnt <= 7'(cnt + 7'h01);
    end
  end

  // One tick every 2^div_sel system clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick <= 1'b0;
    end else begin
      tick <= !restart && ((cnt & mask) == mask); // RULE_22
    end
  end

endmodule : adcs_clkdiv
`default_nettype wire

/* adcs_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module adcs_core_model (
  // Converter controls
  input wire adcs_pkg::adcs_ana_t ana,
  // Level to convert
  input wire logic [11:0] level,
  // Result
  output logic [11:0] core_data
);
  import adcs_pkg::*;

  // An unpowered or idle core shows the inverse, never a stale result
  assign core_data = (ana.power_en && ana.convert) ? level : ~level;

endmodule : adcs_core_model

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import adcs_pkg::*;

  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, irq, eoc, rd_dp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize, src;
  logic [11:0] core_data, level;
  adcs_ana_t ana;
  adcs_pin_t pin;
  logic [31:0] exp_q[$];
  int err_total, comparisons, seed, n_smp, n_cnv, n_eoc, e0, gap, last_gap;

  adcs_top adcs_top_i (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ana(ana), .core_data(core_data), .pin(pin), .irq(irq), .eoc(eoc)
  );

  adcs_core_model adcs_core_model_i (.ana(ana), .level(level), .core_data(core_data));

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Bounded wait for ready sampled high at a rising edge
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(a);
    hsize <= SIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr;
    wait_ready();
    rd_dp <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Read data is compared with the oldest note when the data phase ends
  always @(posedge clk) begin
    if (rd_dp && hreadyout) check(hrdata, exp_q.pop_front());
  end

  // Converter clocks per phase, tick spacing and completion pulses
  always @(posedge clk) begin
    if (ana.clk_tick && ana.sample) n_smp <= n_smp + 1;
    if (ana.clk_tick && ana.convert) n_cnv <= n_cnv + 1;
    if (eoc) n_eoc <= n_eoc + 1;
    gap <= ana.clk_tick ? 1 : gap + 1;
    if (ana.clk_tick) last_gap <= gap;
  end

  task automatic conv(input logic r10, input logic [1:0] rt, input logic [2:0] sr,
                      input logic [2:0] dv, input logic f, input logic [2:0] ic,
                      input logic [11:0] d);
    logic [11:0] w;
    logic [15:0] al;
    logic [7:0] c0;
    int s0, k0, n;
    w = r10 ? (d & 12'h3FF) : d;
    al = r10 ? (f ? {6'h00, w[9:0]} : {w[9:0], 6'h00}) : (f ? {4'h0, w} : {w, 4'h0});
    c0 = {3'b001, f, (sr == SRC_EXT0) ? 4'h3 : 4'h8};
    level <= d;
    bus(1'b1, ADDR_INTC, 32'(ic));
    bus(1'b1, ADDR_CTRL2, 32'({r10, rt, 4'h0, sr == SRC_TSO}));
    bus(1'b1, ADDR_CTRL0, 32'(c0 | 8'h08));
    bus(1'b1, ADDR_CTRL1, 32'({sr, ((sr == SRC_TSO) ? REF_TS : 2'h1), dv}));
    s0 = n_smp;
    k0 = n_cnv;
    e0 = n_eoc;
    bus(1'b1, ADDR_CTRL0, 32'(c0 | 8'h80));
    bus(1'b1, ADDR_CTRL0, 32'(c0));
    @(negedge clk);
    check(32'(ana.sample), 32'h0000_0000);
    @(negedge clk);
    check(32'({ana.sample, ana.convert}), 32'h0000_0002);
    check(32'({ana.ts_en, ana.res10, ana.rate}), 32'({sr == SRC_TSO, r10, rt}));
    @(posedge clk);
    rd(ADDR_CTRL0, 32'(c0 | 8'h40));
    n = 0;
    while (n_eoc == e0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n_eoc == e0) begin
      err_total++;
      end_of_test();
    end
    @(negedge clk);
    check(32'(irq), 32'(ic == 3'h6));
    check(n_smp - s0, r10 ? ((rt == RATE_LOW_CUR) ? 2 : 3) : (sr == SRC_TSO) ? 46 : 4);
    check(n_cnv - k0, r10 ? 10 : 12);
    check(last_gap, 32'(1) << dv);
    @(posedge clk);
    rd(ADDR_CTRL0, 32'(c0));
    rd(ADDR_RES_HI, 32'(al[15:8]));
    rd(ADDR_RES_LO, 32'(al[7:0]));
    rd(ADDR_INTC, 32'(ic | 3'h1));
  endtask : conv

  // Main sequence
  initial begin
    seed = 65637;
    {hsel, haddr, htrans, hwrite, hsize, hwdata, level, rd_dp} = '0;
    rstn = 1'b0;
    repeat (9) @(posedge clk);
    @(negedge clk);
    check(32'(ana), 32'h0000_0000);
    check(pin, 32'h0000_0000);
    @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0000_0000);
    bus(1'b1, ADDR_CTRL2, 32'h0000_00FF);
    bus(1'b1, ADDR_RES_HI, 32'h0000_00FF);
    bus(1'b1, 8'h1C, 32'h0000_00FF);
    bus(1'b1, ADDR_CTRL0, 32'h0000_0040);
    rd(ADDR_CTRL2, 32'h0000_00E1);
    rd(ADDR_RES_HI, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    rd(ADDR_CTRL0, 32'h0000_0000);
    bus(1'b1, ADDR_CTRL2, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      src = (i % 3 == 0) ? SRC_EXT0 : (i % 3 == 1) ? SRC_EXT1 : SRC_EXT2;
      if (i >= 8) src = 3'((i - 8) % 7);
      bus(1'b1, ADDR_CTRL0, 32'h0000_0020 | 32'(i));
      bus(1'b1, ADDR_CTRL1, 32'({src, 2'(i), 3'h0}));
      @(negedge clk);
      v = 32'({i % 4 == 0, i[0], i % 4 == 2});
      check(32'({ana.ref_ext, ana.ref_vdd, ana.ref_tsvref}), v);
      v = 32'({src == 0 || src > 4, src == 1, src == 2, src == 3 || src == 4});
      check(32'({ana.in_ext, ana.in_bandgap, ana.in_tso, ana.in_gnd}), v);
      check(32'(ana.chan), (i < 8) ? 32'(1) << i : 32'h0000_0000);
      @(posedge clk);
    end
    v = $random(seed);
    bus(1'b1, ADDR_CTRL1, {24'h00_0000, 3'h7, v[4:0]});
    rd(ADDR_CTRL1, {24'h00_0000, 3'h0, v[4:0]});
    bus(1'b1, ADDR_CTRL1, {24'h00_0000, SRC_GND1, v[4:0]});
    rd(ADDR_CTRL1, {24'h00_0000, SRC_GND1, v[4:0]});
    v = $random(seed);
    bus(1'b1, ADDR_PINSEL, v);
    @(negedge clk);
    check(pin, {4{v[7:0]}});
    @(posedge clk);
    rd(ADDR_PINSEL, 32'(v[7:0]));
    conv(1'b0, 2'h0, SRC_EXT0, 3'h7, 1'b0, 3'h6, 12'($random(seed)));
    conv(1'b0, 2'h0, SRC_TSO, 3'h0, 1'b1, 3'h2, 12'($random(seed)));
    conv(1'b1, RATE_LOW_CUR, SRC_EXT1, 3'h1, 1'b0, 3'h4, 12'hFFF);
    conv(1'b1, 2'h1, SRC_EXT2, 3'h2, 1'b1, 3'h6, 12'($random(seed)));
    conv(1'b1, 2'h2, SRC_BG, 3'h0, 1'b0, 3'h0, 12'($random(seed)));
    conv(1'b0, 2'h0, SRC_GND0, 3'h3, 1'b1, 3'h6, 12'hFFF);
    bus(1'b1, ADDR_INTC, 32'h0000_0006);
    bus(1'b1, ADDR_CTRL0, 32'h0000_00AB);
    bus(1'b1, ADDR_CTRL0, 32'h0000_002B);
    e0 = n_eoc;
    repeat (4) @(posedge clk);
    bus(1'b1, ADDR_CTRL0, 32'h0000_000B);
    @(negedge clk);
    check(32'(ana), 32'h0000_0000);
    repeat (300) @(posedge clk);
    check(n_eoc - e0, 32'h0000_0000);
    rd(ADDR_CTRL0, 32'h0000_000B);
    rd(ADDR_INTC, 32'h0000_0006);
    end_of_test();
  end

endmodule : testbench

`default_nettype wire
